// *** inc/sadc_cfg.svh ***
// register map, field positions, widths and reset values of the converter control
`ifndef SADC_CFG_SVH
`define SADC_CFG_SVH

`define SADC_RES_W 12
`define SADC_DIV_W 7

`define SADC_OFS_RES_LOW 8'h00
`define SADC_OFS_RES_HIGH 8'h04
`define SADC_OFS_MAIN_CTL 8'h08
`define SADC_OFS_SRC_CLK 8'h0C
`define SADC_OFS_REF_AMP 8'h10
`define SADC_OFS_BANDGAP 8'h14
`define SADC_OFS_IRQ_STAT 8'h18
`define SADC_OFS_IRQ_CLR 8'h1C
`define SADC_OFS_IRQ_EN 8'h20

`define SADC_CTL_START 7
`define SADC_CTL_BUSY 6
`define SADC_CTL_EN 5
`define SADC_CTL_ALIGN 4

`define SADC_SRC_LSB 4
`define SADC_REF_AMP_MASK 8'h9F
`define SADC_BANDGAP_BIT 0

`define SADC_IRQ_W 2
`define SADC_IRQ_DONE 0
`define SADC_IRQ_DROP 1

`define SADC_MAIN_CTL_RST 8'h00
`define SADC_SRC_CLK_RST 8'h00
`define SADC_REF_AMP_RST 8'h00
`define SADC_BANDGAP_RST 1'h0
`define SADC_RESULT_RST 12'h000
`define SADC_IRQ_RST 2'h0

`endif

// *** inc/sadc_pkg.sv ***
// types shared by the converter control modules
package sadc_pkg;

  typedef enum logic [1:0] {
    SADC_IDLE = 2'h0,
    SADC_ARM = 2'h1,
    SADC_CONV = 2'h3,
    SADC_LOAD = 2'h2
  } sadc_seq_state_t;

  typedef struct packed {
    sadc_seq_state_t state;
    logic [6:0] div;
    logic [11:0] result;
    logic core_start;
    logic clk_en;
  } sadc_seq_st_t;

  typedef struct packed {
    logic start;
    logic en;
    logic align;
    logic [3:0] chsel;
    logic [3:0] src_sel;
    logic [2:0] clk_sel;
    logic [7:0] ref_amp;
    logic bg_en;
    logic [11:0] result;
    logic [1:0] irq_stat;
    logic [1:0] irq_en;
    logic [31:0] prdata;
    logic [15:0] ext_chan;
    logic [15:0] pin_off;
    logic start_req;
  } sadc_regs_st_t;

endpackage : sadc_pkg

// *** inc/sadc_seq_if.sv ***
// link between the register file and the conversion sequencer
`timescale 1ns/100ps
interface sadc_seq_if;
  logic start_req;
  logic enable;
  logic [2:0] clk_sel;
  logic busy;
  logic load;
  logic [11:0] result;

  modport ctrl (
    output start_req,
    output enable,
    output clk_sel,
    input busy,
    input load,
    input result
  );

  modport seq (
    input start_req,
    input enable,
    input clk_sel,
    output busy,
    output load,
    output result
  );
endinterface : sadc_seq_if

// *** hw/sadc_seq.sv ***
// conversion clock divider and busy sequencer
`timescale 1ns/100ps
`include "sadc_cfg.svh"
module sadc_seq (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // register file side
  sadc_seq_if.seq ctl,
  // analog core
  input wire logic i_core_done,
  input wire logic [`SADC_RES_W-1:0] i_core_result,
  output logic o_core_clk_en,
  output logic o_core_start
);

  sadc_pkg::sadc_seq_st_t q;
  sadc_pkg::sadc_seq_st_t d;
  logic [7:0] mask8;
  logic tick;

  always_comb
  begin
    d = q;
    d.core_start = 1'b0;
    d.clk_en = 1'b0;
    mask8 = 8'(8'h01 << ctl.clk_sel) - 8'h01;
    tick = (q.div & mask8[6:0]) == mask8[6:0];
    if (!ctl.enable)
    begin
      // disabling aborts: no load, result kept
      d.div = '0;
      d.state = sadc_pkg::SADC_IDLE;
    end
    else
    begin
      d.div = q.div + 7'h01;
      d.clk_en = tick;
      unique case (q.state)
        sadc_pkg::SADC_IDLE:
        begin
          if (ctl.start_req)
          begin
            d.state = sadc_pkg::SADC_ARM;
          end
        end
        sadc_pkg::SADC_ARM:
        begin
          // start aligned to a conversion clock enable
          if (tick)
          begin
            d.core_start = 1'b1;
            d.state = sadc_pkg::SADC_CONV;
          end
        end
        sadc_pkg::SADC_CONV:
        begin
          if (i_core_done)
          begin
            d.result = i_core_result;
            d.state = sadc_pkg::SADC_LOAD;
          end
        end
        sadc_pkg::SADC_LOAD:
        begin
          d.state = sadc_pkg::SADC_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign ctl.busy = q.state != sadc_pkg::SADC_IDLE;
  assign ctl.load = q.state == sadc_pkg::SADC_LOAD;
  assign ctl.result = q.result;
  assign o_core_clk_en = q.clk_en;
  assign o_core_start = q.core_start;

endmodule : sadc_seq

// *** hw/sadc_regs.sv ***
// converter control: APB register file, result formatting, input routing, interrupt
//
// Overview of operation
// - every result is twelve bits wide
// - alignment bit picks the result byte layout
// - unused result bits read as zero
// - result kept unchanged while converter disabled
// - start bit high then low starts conversion
// - busy set at start, cleared at completion
// - enable bit powers the converter
// - channel codes map to inputs 0-2,9-11,13-15
// - internal source disconnects external channel
// - analog pins lose shared functions and pull-high
// - main control register resets to zero
// - clock select divides by 1 to 128
// - source code decodes external, ground, internal
//
// Our own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "sadc_cfg.svh"
module sadc_regs (
  // clock and reset
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  // APB slave
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  // interrupt
  output logic o_irq,
  // analog core
  output logic o_core_power_en,
  output logic o_core_clk_en,
  output logic o_core_start,
  input wire logic i_core_done,
  input wire logic [`SADC_RES_W-1:0] i_core_result,
  // input routing
  output logic [3:0] o_src_sel,
  output logic o_src_internal,
  output logic o_src_ground,
  output logic [15:0] o_ext_chan_sel,
  output logic [7:0] o_ref_amp_ctrl,
  output logic o_bandgap_en,
  // shared pins
  input wire logic [15:0] i_pin_analog_sel,
  output logic [15:0] o_pin_shared_off,
  output logic [15:0] o_pin_pullup_off
);

  sadc_pkg::sadc_regs_st_t q;
  sadc_pkg::sadc_regs_st_t d;
  sadc_seq_if seq_bus ();

  logic setup;
  logic wr_acc;
  logic mapped;
  logic [7:0] wbyte;
  logic src_external;
  logic [15:0] chan_hit;
  logic [1:0] irq_set;
  logic start_fall;
  logic [15:0] res_fmt;

  // channel codes that name a real input
  function automatic logic chan_valid(input logic [3:0] code);
    logic ok;
    ok = 1'b0;
    if (code <= 4'h2)
    begin
      ok = 1'b1;
    end
    else if (code >= 4'h9 && code != 4'hC)
    begin
      ok = 1'b1;
    end
    return ok;
  endfunction : chan_valid

  // result pair layout; unused bits forced low
  function automatic logic [15:0] fmt_result(
    input logic [11:0] res,
    input logic align
  );
    logic [15:0] v;
    v = 16'h0000;
    if (align)
    begin
      v = {4'h0, res};
    end
    else
    begin
      v = {res, 4'h0};
    end
    return v;
  endfunction : fmt_result

  always_comb
  begin
    mapped = 1'b0;
    unique case (i_paddr)
      `SADC_OFS_RES_LOW,
      `SADC_OFS_RES_HIGH,
      `SADC_OFS_MAIN_CTL,
      `SADC_OFS_SRC_CLK,
      `SADC_OFS_REF_AMP,
      `SADC_OFS_BANDGAP,
      `SADC_OFS_IRQ_STAT,
      `SADC_OFS_IRQ_CLR,
      `SADC_OFS_IRQ_EN:
      begin
        mapped = 1'b1;
      end
      default:
      begin
        mapped = 1'b0;
      end
    endcase
  end

  assign setup = i_psel && !i_penable;
  // only the low lane carries register data
  assign wr_acc = i_psel && i_penable && i_pwrite && mapped && i_pstrb[0];
  assign wbyte = i_pwdata[7:0];
  assign res_fmt = fmt_result(q.result, q.align);

  // source codes 0000, 0100 and 11xx use the external channel
  assign src_external = (q.src_sel == 4'h0) || (q.src_sel == 4'h4) ||
    (q.src_sel[3:2] == 2'h3);

  genvar g;
  generate
    for (g = 0; g < 16; g++)
    begin : g_chan
      // reserved codes and internal sources select no pin
      assign chan_hit[g] = src_external && chan_valid(q.chsel) &&
        (q.chsel == 4'(g));
    end
  endgenerate

  always_comb
  begin
    d = q;
    d.start_req = 1'b0;
    irq_set = '0;
    start_fall = 1'b0;

    if (seq_bus.load)
    begin
      d.result = seq_bus.result;
      irq_set[`SADC_IRQ_DONE] = 1'b1;
    end

    if (wr_acc)
    begin
      unique case (i_paddr)
        `SADC_OFS_MAIN_CTL:
        begin
          // busy is read-only and not stored
          start_fall = q.start && !wbyte[`SADC_CTL_START];
          d.start = wbyte[`SADC_CTL_START];
          d.en = wbyte[`SADC_CTL_EN];
          d.align = wbyte[`SADC_CTL_ALIGN];
          d.chsel = wbyte[3:0];
        end
        `SADC_OFS_SRC_CLK:
        begin
          d.src_sel = wbyte[7:`SADC_SRC_LSB];
          d.clk_sel = wbyte[2:0];
        end
        `SADC_OFS_REF_AMP:
        begin
          d.ref_amp = wbyte & `SADC_REF_AMP_MASK;
        end
        `SADC_OFS_BANDGAP:
        begin
          d.bg_en = wbyte[`SADC_BANDGAP_BIT];
        end
        `SADC_OFS_IRQ_CLR:
        begin
          d.irq_stat = q.irq_stat & ~wbyte[1:0];
        end
        `SADC_OFS_IRQ_EN:
        begin
          d.irq_en = wbyte[1:0];
        end
        default:
        begin
          d.irq_en = q.irq_en;
        end
      endcase
    end

    // a start is only honoured when enabled and idle
    if (start_fall)
    begin
      if (q.en && d.en && !seq_bus.busy && !q.start_req)
      begin
        d.start_req = 1'b1;
      end
      else
      begin
        irq_set[`SADC_IRQ_DROP] = 1'b1;
      end
    end

    // set wins over a clear in the same cycle
    d.irq_stat = d.irq_stat | irq_set;

    d.ext_chan = chan_hit;
    d.pin_off = i_pin_analog_sel;

    // read data captured in the setup phase, zero wait states
    if (setup && !i_pwrite)
    begin
      unique case (i_paddr)
        `SADC_OFS_RES_LOW:
        begin
          d.prdata = {24'h000000, res_fmt[7:0]};
        end
        `SADC_OFS_RES_HIGH:
        begin
          d.prdata = {24'h000000, res_fmt[15:8]};
        end
        `SADC_OFS_MAIN_CTL:
        begin
          d.prdata = {24'h000000, q.start, seq_bus.busy, q.en, q.align, q.chsel};
        end
        `SADC_OFS_SRC_CLK:
        begin
          d.prdata = {24'h000000, q.src_sel, 1'b0, q.clk_sel};
        end
        `SADC_OFS_REF_AMP:
        begin
          d.prdata = {24'h000000, q.ref_amp};
        end
        `SADC_OFS_BANDGAP:
        begin
          d.prdata = {31'h00000000, q.bg_en};
        end
        `SADC_OFS_IRQ_STAT:
        begin
          d.prdata = {30'h00000000, q.irq_stat};
        end
        `SADC_OFS_IRQ_EN:
        begin
          d.prdata = {30'h00000000, q.irq_en};
        end
        default:
        begin
          d.prdata = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      q <= '0;
      q.start <= 1'(`SADC_MAIN_CTL_RST >> `SADC_CTL_START);
      q.en <= 1'b0;
      q.align <= 1'b0;
      q.chsel <= 4'h0;
      q.src_sel <= 4'h0;
      q.clk_sel <= 3'h0;
      q.ref_amp <= `SADC_REF_AMP_RST;
      q.bg_en <= `SADC_BANDGAP_RST;
      q.result <= `SADC_RESULT_RST;
      q.irq_stat <= `SADC_IRQ_RST;
      q.irq_en <= `SADC_IRQ_RST;
    end
    else
    begin
      q <= d;
    end
  end

  assign seq_bus.start_req = q.start_req;
  assign seq_bus.enable = q.en;
  assign seq_bus.clk_sel = q.clk_sel;

  sadc_seq u_seq (
    .i_ref_clk(i_ref_clk),
    .i_rst_b(i_rst_b),
    .ctl(seq_bus),
    .i_core_done(i_core_done),
    .i_core_result(i_core_result),
    .o_core_clk_en(o_core_clk_en),
    .o_core_start(o_core_start)
  );

  assign o_prdata = q.prdata;
  assign o_pready = 1'b1;
  assign o_pslverr = i_psel && i_penable && !mapped;
  assign o_irq = |(q.irq_stat & q.irq_en);
  assign o_core_power_en = q.en;
  assign o_src_sel = q.src_sel;
  assign o_src_internal = !src_external;
  assign o_src_ground = q.src_sel[3:2] == 2'h2;
  assign o_ext_chan_sel = q.ext_chan;
  assign o_ref_amp_ctrl = q.ref_amp;
  assign o_bandgap_en = q.bg_en;
  assign o_pin_shared_off = q.pin_off;
  assign o_pin_pullup_off = q.pin_off;

endmodule : sadc_regs

// *** sim/sadc_core_model.sv ***
// behavioural analog core: answers a start after a number of conversion ticks
`timescale 1ns/100ps
module sadc_core_model #(
  parameter int TICKS = 6
) (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_rst_b,
  // control from the block
  input wire logic i_power_en,
  input wire logic i_clk_en,
  input wire logic i_start,
  input wire logic [11:0] i_value,
  // answer
  output logic o_done,
  output logic [11:0] o_result
);
  int cnt;
  logic [11:0] last;
  always @(posedge i_clk or negedge i_rst_b)
    if (!i_rst_b)
    begin
      cnt <= 0;
      o_done <= 1'b0;
      o_result <= 12'h000;
      last <= 12'h000;
    end
    else
    begin
      o_done <= 1'b0;
      // result bus is not valid outside the done pulse
      o_result <= ~last;
      if (!i_power_en)
        cnt <= 0;
      else if (i_start)
        cnt <= TICKS;
      else if (cnt > 0 && i_clk_en)
      begin
        cnt <= cnt - 1;
        if (cnt == 1)
        begin
          o_done <= 1'b1;
          o_result <= i_value;
          last <= i_value;
        end
      end
    end
endmodule : sadc_core_model

// *** sim/sadc_regs_checker.sv ***
// port assertions for the converter control block
`timescale 1ns/100ps
module sadc_regs_checker (
  // clock, reset, bus
  input wire logic i_ref_clk,
  input wire logic i_rst_b,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [3:0] i_pstrb,
  input wire logic o_pready,
  input wire logic o_pslverr,
  // core and routing
  input wire logic o_core_power_en,
  input wire logic o_core_clk_en,
  input wire logic o_core_start,
  input wire logic [3:0] o_src_sel,
  input wire logic o_src_internal,
  input wire logic o_src_ground,
  input wire logic [15:0] o_ext_chan_sel,
  input wire logic [15:0] i_pin_analog_sel,
  input wire logic [15:0] o_pin_shared_off,
  input wire logic [15:0] o_pin_pullup_off
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_b);
  sequence s_wr_main;
    i_psel && i_penable && i_pwrite && i_pstrb[0] && i_paddr == 8'h08;
  endsequence
  sequence s_off_two;
    !o_core_power_en ##1 !o_core_power_en;
  endsequence
  a_ready_const:
    assert property (o_pready) else $error("pready low");
  a_err_access:
    assert property (o_pslverr |-> i_psel && i_penable) else $error("pslverr outside access");
  a_power_write:
    assert property (s_wr_main |=> o_core_power_en == $past(i_pwdata[5]))
    else $error("power enable not following write");
  a_off_no_start:
    assert property (s_off_two |-> !o_core_start) else $error("start while off");
  a_start_tick:
    assert property (o_core_start |-> o_core_clk_en) else $error("start off tick");
  a_chan_legal:
    assert property ((o_ext_chan_sel & 16'h11F8) == 16'h0000 && $onehot0(o_ext_chan_sel))
    else $error("illegal channel select");
  a_src_decode:
    assert property (o_src_ground == (o_src_sel[3:2] == 2'b10) && o_src_internal ==
      !(o_src_sel == 4'h0 || o_src_sel == 4'h4 || o_src_sel[3:2] == 2'b11))
    else $error("source decode wrong");
  a_int_no_chan:
    assert property (o_src_internal && $past(o_src_internal) |-> o_ext_chan_sel == 16'h0000)
    else $error("channel on with internal source");
  a_pin_follow:
    assert property ($past(i_rst_b) |-> o_pin_shared_off == $past(i_pin_analog_sel) &&
      o_pin_pullup_off == $past(i_pin_analog_sel)) else $error("pin release wrong");
endmodule : sadc_regs_checker

bind sadc_regs sadc_regs_checker sadc_regs_checker_inst (.i_ref_clk, .i_rst_b, .i_psel,
  .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .i_pstrb, .o_pready, .o_pslverr,
  .o_core_power_en, .o_core_clk_en, .o_core_start, .o_src_sel, .o_src_internal,
  .o_src_ground, .o_ext_chan_sel, .i_pin_analog_sel, .o_pin_shared_off, .o_pin_pullup_off);

// *** sim/test_sar_adc_control_regs.sv ***
// self-checking bench for the converter control block
`timescale 1ns/100ps
module test_sar_adc_control_regs;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic [15:0] pins = 16'h0000, chan, shoff, puoff;
  logic pready, pslverr, irq, pwen, clken, cstart, done, sint, sgnd;
  logic [11:0] cres, value = 12'h000;
  logic [3:0] ssel;
  logic [7:0] ramp;
  logic bgen;
  int err_count = 0;
  int tests_run = 0;
  always #4 clk = ~clk;
  sadc_regs sadc_regs_inst (.i_ref_clk(clk), .i_rst_b(rst_b), .i_psel(psel),
    .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(4'hF),
    .o_prdata(prdata), .o_pready(pready), .o_pslverr(pslverr), .o_irq(irq),
    .o_core_power_en(pwen), .o_core_clk_en(clken), .o_core_start(cstart),
    .i_core_done(done), .i_core_result(cres), .o_src_sel(ssel), .o_src_internal(sint),
    .o_src_ground(sgnd), .o_ext_chan_sel(chan), .o_ref_amp_ctrl(ramp), .o_bandgap_en(bgen),
    .i_pin_analog_sel(pins), .o_pin_shared_off(shoff), .o_pin_pullup_off(puoff));
  sadc_core_model #(.TICKS(6)) sadc_core_model_inst (.i_clk(clk), .i_rst_b(rst_b),
    .i_power_en(pwen), .i_clk_en(clken), .i_start(cstart), .i_value(value),
    .o_done(done), .o_result(cres));
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      err_count++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask : chk
  // one idle cycle after each transfer keeps strobes from toggling twice per step
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
    output logic [31:0] q, output logic e);
    int n;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    if (n >= 50)
    begin
      err_count++;
      wrap_up;
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
    @(posedge clk);
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(n, x, q);
  endtask : rdc
  task automatic t_reset;
    rdc("main_ctl", 8'h08, 32'h0);
    rdc("res_low", 8'h00, 32'h0);
    rdc("res_high", 8'h04, 32'h0);
    rdc("src_clk", 8'h0C, 32'h0);
    chk("irq", 32'h0, {31'h0, irq});
  endtask : t_reset
  task automatic t_bus;
    logic [31:0] q;
    logic e;
    apb(1'b0, 8'h24, 32'h0, q, e);
    chk("unmapped_err", 32'h1, {31'h0, e});
    chk("unmapped_data", 32'h0, q);
    apb(1'b0, 8'h1C, 32'h0, q, e);
    chk("clear_err", 32'h0, {31'h0, e});
    pins <= 16'hA5C3;
    repeat (2) @(posedge clk);
    chk("shared_off", 32'h0000A5C3, {16'h0, shoff});
    chk("pullup_off", 32'h0000A5C3, {16'h0, puoff});
  endtask : t_bus
  task automatic t_route;
    logic ok;
    for (int i = 0; i < 16; i++)
    begin
      ok = i <= 2 || (i >= 9 && i <= 11) || i >= 13;
      // reserved channel codes are never programmed
      if (!ok) continue;
      wr(8'h08, 32'(i));
      // channel select is registered one edge after the write
      @(posedge clk);
      chk("chan", ok ? 32'(1) << i : 32'h0, {16'h0, chan});
    end
    for (int s = 0; s < 16; s++)
    begin
      wr(8'h0C, 32'(s) << 4);
      @(posedge clk);
      ok = !(s == 0 || s == 4 || s >= 12);
      chk("src_sel", 32'(s), {28'h0, ssel});
      chk("internal", {31'h0, ok}, {31'h0, sint});
      chk("ground", {31'h0, s >= 8 && s < 12}, {31'h0, sgnd});
      // channel select still holds code 15 from the loop above
      chk("chan_src", ok ? 32'h0 : 32'h8000, {16'h0, chan});
    end
  endtask : t_route
  task automatic t_div;
    int m;
    wr(8'h08, 32'h20);
    for (int s = 0; s < 8; s++)
    begin
      wr(8'h0C, 32'(s));
      m = 0;
      do
      begin
        @(posedge clk);
        m++;
      end
      while (clken !== 1'b1 && m < 300);
      if (m >= 300)
      begin
        err_count++;
        wrap_up;
      end
      m = 0;
      do
      begin
        @(posedge clk);
        m++;
      end
      while (clken !== 1'b1 && m < 300);
      if (m >= 300)
      begin
        err_count++;
        wrap_up;
      end
      chk("tick_gap", 32'(1) << s, 32'(m));
    end
    wr(8'h0C, 32'h0);
  endtask : t_div
  task automatic t_convert(input logic [3:0] ch, input logic al, input logic [11:0] v);
    logic [31:0] q;
    logic e;
    logic [7:0] c;
    int n;
    c = {3'b001, al, ch};
    value <= v;
    wr(8'h08, {24'h0, c});
    wr(8'h08, {24'h0, c | 8'h80});
    rdc("no_early_start", 8'h08, {24'h0, c | 8'h80});
    wr(8'h08, {24'h0, c});
    rdc("busy_set", 8'h08, {24'h0, c | 8'h40});
    n = 0;
    do
    begin
      apb(1'b0, 8'h08, 32'h0, q, e);
      n++;
    end
    while (q[6] !== 1'b0 && n < 200);
    if (n >= 200)
    begin
      err_count++;
      wrap_up;
    end
    chk("busy_clear", {24'h0, c}, q);
    rdc("res_high", 8'h04, al ? {28'h0, v[11:8]} : {24'h0, v[11:4]});
    rdc("res_low", 8'h00, al ? {24'h0, v[7:0]} : {24'h0, v[3:0], 4'h0});
  endtask : t_convert
  task automatic t_irq;
    rdc("irq_stat", 8'h18, 32'h1);
    chk("irq_masked", 32'h0, {31'h0, irq});
    wr(8'h20, 32'h1);
    chk("irq_on", 32'h1, {31'h0, irq});
    wr(8'h1C, 32'h1);
    chk("irq_off", 32'h0, {31'h0, irq});
    rdc("irq_cleared", 8'h18, 32'h0);
  endtask : t_irq
  task automatic t_disabled;
    wr(8'h08, 32'h10);
    chk("power_off", 32'h0, {31'h0, pwen});
    wr(8'h08, 32'h90);
    wr(8'h08, 32'h10);
    rdc("no_busy", 8'h08, 32'h10);
    rdc("kept_low", 8'h00, 32'hA3);
    rdc("kept_high", 8'h04, 32'h5);
    rdc("drop_stat", 8'h18, 32'h2);
  endtask : t_disabled
  task automatic t_misc;
    wr(8'h10, 32'hFF);
    rdc("ref_amp", 8'h10, 32'h9F);
    chk("ref_amp_out", 32'h9F, {24'h0, ramp});
    wr(8'h14, 32'hFF);
    rdc("bandgap", 8'h14, 32'h1);
    chk("bandgap_out", 32'h1, {31'h0, bgen});
  endtask : t_misc
  initial
  begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    t_reset;
    t_bus;
    t_route;
    t_div;
    t_convert(4'h2, 1'b0, 12'hABC);
    t_convert(4'hD, 1'b1, 12'h5A3);
    t_irq;
    t_disabled;
    t_misc;
    wrap_up;
  end
endmodule : test_sar_adc_control_regs
